// ==== rtl/nfc_timer_pkg.sv ====
// Functional notes
// - Clear command stops all timers but wake-up and mode-1 no-response
// - Transmit end starts no-response timer; mask timer only outside active mode
// - Receive enable low while mask timer runs
// - Squelch follows mask timer; mask expiry no interrupt
// - Active mode: peer field on starts mask timer
// - Low-power target: command start, 512-period step
// - No-response expiry sets its own flag
// - Step bit picks 64 or 4096 periods
// - Mode 0: reply stops silently, expiry interrupts
// - Mode 1: always interrupt, clear ignored
// - No-response command starts or restarts timer
// - Active mode ignores no-response start command
// - Active mode: expiry before peer field interrupts
// - General timer trigger: SOF, EOF or field off
// - General timer expiry always interrupts
// - General timer command starts or restarts it
// - Wake command accepted outside wake mode
// - Wake expiry sets the wake timer flag
// - Carrier timers need the crystal running
// - Wake timeouts 10 to 800 ms, 100 default
package nfc_timer_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;

  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MRT  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_NRT  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_GPT  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_WUT  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CMD  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ  = 8'h1c;

  localparam int CTRL_W      = 8;
  localparam int CB_NRT_MODE = 0;
  localparam int CB_NRT_STEP = 1;
  localparam int CB_GPT_TRIG = 2;
  localparam int CB_SQ_EN    = 4;
  localparam int CB_ACTIVE   = 5;
  localparam int CB_LP_TGT   = 6;
  localparam int CB_WAKE     = 7;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;

  typedef enum logic [1:0] {
    GT_NONE = 2'b00,
    GT_SOF  = 2'b01,
    GT_EOF  = 2'b10,
    GT_RSV  = 2'b11
  } gpt_trig_t;

  localparam int MRT_W = 8;
  localparam int CNT_W = 16;
  localparam int WUT_W = 3;
  localparam logic [MRT_W-1:0] MRT_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [WUT_W-1:0] WUT_RST = 3'h2;

  localparam int CMD_W = 5;
  localparam int C_CLR = 0;
  localparam int C_MRT = 1;
  localparam int C_NRT = 2;
  localparam int C_GPT = 3;
  localparam int C_WUT = 4;

  localparam int IRQ_W  = 3;
  localparam int IB_NRE = 0;
  localparam int IB_GPT = 1;
  localparam int IB_WT  = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  localparam int NT    = 4;
  localparam int T_MRT = 0;
  localparam int T_NRT = 1;
  localparam int T_GPT = 2;
  localparam int T_WUT = 3;
  localparam int SB_RXON  = 4;
  localparam int SB_SQ    = 5;
  localparam int SB_FORCE = 6;

  // Carrier-period steps, all powers of two so a mask picks the step edge
  localparam int FC_CNT_W = 12;
  localparam logic [FC_CNT_W-1:0] FC_RST          = 12'h000;
  localparam logic [FC_CNT_W-1:0] FC_ONE          = 12'h001;
  localparam logic [FC_CNT_W-1:0] STEP_MASK_64    = 12'h03f;
  localparam logic [FC_CNT_W-1:0] STEP_MASK_512   = 12'h1ff;
  localparam logic [FC_CNT_W-1:0] STEP_MASK_4096  = 12'hfff;
  localparam logic [FC_CNT_W-1:0] STEP_MASK_GPT   = 12'h007;

  localparam int RC_HZ           = 32000;
  localparam int RC_TICKS_PER_MS = RC_HZ / 1000;
  localparam logic [9:0] WUT_MS [8] = '{10'd10, 10'd50, 10'd100, 10'd200,
                                        10'd300, 10'd400, 10'd500, 10'd800};

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ==== rtl/nfc_timer_unit.sv ====
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module nfc_timer_unit (
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  input  wire logic [nfc_timer_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  input  wire logic [nfc_timer_pkg::DATA_W-1:0]    s_axi_wdata,
  input  wire logic [nfc_timer_pkg::STRB_W-1:0]    s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  output logic [1:0]                               s_axi_bresp,
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  input  wire logic [nfc_timer_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  output logic [nfc_timer_pkg::DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  input  wire logic                                fc_tick,
  input  wire logic                                osc_ok,
  input  wire logic                                rc_tick,
  input  wire logic                                tx_eof_done,
  input  wire logic                                rx_sof,
  input  wire logic                                rx_eof,
  input  wire logic                                rx_busy,
  input  wire logic                                peer_field_on,
  input  wire logic                                peer_field_off,
  output logic                                     rx_on,
  output logic                                     squelch_on,
  output logic                                     rc_osc_on
);
  import nfc_timer_pkg::*;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a == OFS_CTRL) || (a == OFS_MRT) || (a == OFS_NRT) || (a == OFS_GPT) ||
               (a == OFS_WUT) || (a == OFS_CMD) || (a == OFS_STAT) || (a == OFS_IRQ);
  endfunction

  function automatic logic step_hit(input logic [FC_CNT_W-1:0] c,
                                    input logic [FC_CNT_W-1:0] m);
    step_hit = (c & m) == m;
  endfunction

  // Bus slave state
  logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic              aw_have_q, w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [DATA_W-1:0] w_data_q;
  logic [STRB_W-1:0] w_strb_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [DATA_W-1:0] rdata_q;

  wire aw_hs    = s_axi_awvalid & awready_q;
  wire w_hs     = s_axi_wvalid & wready_q;
  wire ar_hs    = s_axi_arvalid & arready_q;
  wire do_write = aw_have_q & w_have_q & ~bvalid_q;
  wire aw_have_d = aw_hs | (aw_have_q & ~do_write);
  wire w_have_d  = w_hs | (w_have_q & ~do_write);
  wire bvalid_d  = do_write | (bvalid_q & ~s_axi_bready);
  wire rvalid_d  = ar_hs | (rvalid_q & ~s_axi_rready);

  wire [DATA_W-1:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                             {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [DATA_W-1:0] wd_m = w_data_q & wmask;

  wire wr_ctrl = do_write & (aw_addr_q == OFS_CTRL);
  wire wr_mrt  = do_write & (aw_addr_q == OFS_MRT);
  wire wr_nrt  = do_write & (aw_addr_q == OFS_NRT);
  wire wr_gpt  = do_write & (aw_addr_q == OFS_GPT);
  wire wr_wut  = do_write & (aw_addr_q == OFS_WUT);
  wire wr_cmd  = do_write & (aw_addr_q == OFS_CMD);
  wire wr_irq  = do_write & (aw_addr_q == OFS_IRQ);

  // Configuration registers
  logic [CTRL_W-1:0] ctrl_q;
  logic [MRT_W-1:0]  mrt_q;
  logic [CNT_W-1:0]  nrt_q, gpt_q;
  logic [WUT_W-1:0]  wut_q;
  logic [IRQ_W-1:0]  irq_q;

  // Byte strobes are honoured; untouched lanes keep their old value
  wire [DATA_W-1:0] ctrl_m = ({{(DATA_W-CTRL_W){1'b0}}, ctrl_q} & ~wmask) | wd_m;
  wire [DATA_W-1:0] mrt_m  = ({{(DATA_W-MRT_W){1'b0}}, mrt_q} & ~wmask) | wd_m;
  wire [DATA_W-1:0] nrt_m  = ({{(DATA_W-CNT_W){1'b0}}, nrt_q} & ~wmask) | wd_m;
  wire [DATA_W-1:0] gpt_m  = ({{(DATA_W-CNT_W){1'b0}}, gpt_q} & ~wmask) | wd_m;
  wire [DATA_W-1:0] wut_m  = ({{(DATA_W-WUT_W){1'b0}}, wut_q} & ~wmask) | wd_m;

  // Retuning a running timer is not guarded here: software must stop it first
  wire [CTRL_W-1:0] ctrl_d = wr_ctrl ? ctrl_m[CTRL_W-1:0] : ctrl_q;
  wire [MRT_W-1:0]  mrt_d  = wr_mrt ? mrt_m[MRT_W-1:0] : mrt_q;
  wire [CNT_W-1:0]  nrt_d  = wr_nrt ? nrt_m[CNT_W-1:0] : nrt_q;
  wire [CNT_W-1:0]  gpt_d  = wr_gpt ? gpt_m[CNT_W-1:0] : gpt_q;
  wire [WUT_W-1:0]  wut_d  = wr_wut ? wut_m[WUT_W-1:0] : wut_q;

  wire [CMD_W-1:0] cmd_v = wr_cmd ? wd_m[CMD_W-1:0] : '0;
  wire             mode1  = ctrl_q[CB_NRT_MODE];
  wire             active = ctrl_q[CB_ACTIVE];
  wire             wake   = ctrl_q[CB_WAKE];
  wire gpt_trig_t  trig   = gpt_trig_t'(ctrl_q[CB_GPT_TRIG +: 2]);

  // Timer core
  logic [FC_CNT_W-1:0] fc_cnt_q;
  logic [CNT_W-1:0]    cnt_q [NT];
  logic [CNT_W-1:0]    cnt_d [NT];
  logic [CNT_W-1:0]    tload [NT];
  logic [NT-1:0]       run_q, exp_q;
  logic [NT-1:0]       run_d, exp_d, tstart, tstop, ttick;
  logic                force_q, rx_on_q, squelch_q, rc_osc_q;

  // Carrier ticks only count while the crystal is up
  wire                fc_ok    = fc_tick & osc_ok;
  wire [FC_CNT_W-1:0] fc_cnt_d = fc_ok ? fc_cnt_q + FC_ONE : fc_cnt_q;
  wire [FC_CNT_W-1:0] mrt_mask = ctrl_q[CB_LP_TGT] ? STEP_MASK_512 : STEP_MASK_64;
  wire [FC_CNT_W-1:0] nrt_mask = ctrl_q[CB_NRT_STEP] ? STEP_MASK_4096 : STEP_MASK_64;
  wire [CNT_W-1:0]    wut_load = CNT_W'(int'(WUT_MS[wut_q]) * RC_TICKS_PER_MS);

  wire reply_start = active ? peer_field_on : rx_sof;
  wire gpt_event   = active ? peer_field_off :
                     ((trig == GT_SOF) & rx_sof) | ((trig == GT_EOF) & rx_eof);

  assign tstart[T_MRT] = (tx_eof_done & ~active) | (peer_field_on & active) | cmd_v[C_MRT];
  assign tstart[T_NRT] = tx_eof_done | (cmd_v[C_NRT] & ~active);
  assign tstart[T_GPT] = gpt_event | cmd_v[C_GPT];
  assign tstart[T_WUT] = (cmd_v[C_WUT] | (wake & ~run_q[T_WUT])) & (wake ^ cmd_v[C_WUT]);

  assign tstop[T_MRT] = cmd_v[C_CLR];
  assign tstop[T_NRT] = ~mode1 & (cmd_v[C_CLR] | reply_start);
  assign tstop[T_GPT] = cmd_v[C_CLR];
  assign tstop[T_WUT] = 1'b0;

  assign ttick[T_MRT] = fc_ok & step_hit(fc_cnt_q, mrt_mask);
  assign ttick[T_NRT] = fc_ok & step_hit(fc_cnt_q, nrt_mask);
  assign ttick[T_GPT] = fc_ok & step_hit(fc_cnt_q, STEP_MASK_GPT);
  assign ttick[T_WUT] = rc_tick;

  assign tload[T_MRT] = {{(CNT_W-MRT_W){1'b0}}, mrt_q};
  assign tload[T_NRT] = nrt_q;
  assign tload[T_GPT] = gpt_q;
  assign tload[T_WUT] = wut_load;

  genvar gi;
  generate
    for (gi = 0; gi < NT; gi++) begin : g_tmr
      // A start always reloads, so a start during a run restarts the count
      assign exp_d[gi] = ~tstart[gi] & ~tstop[gi] & run_q[gi] & ttick[gi] &
                         (cnt_q[gi] == CNT_ONE);
      assign run_d[gi] = tstart[gi] ? (tload[gi] != CNT_RST) :
                         (run_q[gi] & ~tstop[gi] & ~exp_d[gi]);
      assign cnt_d[gi] = tstart[gi] ? tload[gi] :
                         ((run_q[gi] & ttick[gi] & ~tstop[gi]) ? cnt_q[gi] - CNT_ONE : cnt_q[gi]);
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cnt_q[gi] <= CNT_RST;
          run_q[gi] <= 1'b0;
          exp_q[gi] <= 1'b0;
        end else begin
          cnt_q[gi] <= cnt_d[gi];
          run_q[gi] <= run_d[gi];
          exp_q[gi] <= exp_d[gi];
        end
      end
    end
  endgenerate

  // Forced receive-off holds until the next mask or no-response timer start, by frame, peer field or command
  wire force_set = exp_q[T_NRT] & (~mode1 | ~rx_busy);
  wire force_d   = force_set | (force_q & ~(tstart[T_MRT] | tstart[T_NRT]));
  wire rx_on_d   = ~run_d[T_MRT] & ~force_d;
  wire sq_d      = ctrl_q[CB_SQ_EN] & run_d[T_MRT];

  // Mask expiry has no flag; a new event beats a same-cycle write-one-clear
  wire [IRQ_W-1:0] irq_set = {exp_q[T_WUT], exp_q[T_GPT], exp_q[T_NRT]};
  wire [IRQ_W-1:0] irq_clr = wr_irq ? wd_m[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] irq_d   = irq_set | (irq_q & ~irq_clr);

  // Read decode
  wire [DATA_W-1:0] stat_w = {{(DATA_W-7){1'b0}}, force_q, squelch_q, rx_on_q, run_q};
  wire [DATA_W-1:0] rd_w =
    (s_axi_araddr == OFS_CTRL) ? {{(DATA_W-CTRL_W){1'b0}}, ctrl_q} :
    (s_axi_araddr == OFS_MRT)  ? {{(DATA_W-MRT_W){1'b0}}, mrt_q} :
    (s_axi_araddr == OFS_NRT)  ? {{(DATA_W-CNT_W){1'b0}}, nrt_q} :
    (s_axi_araddr == OFS_GPT)  ? {{(DATA_W-CNT_W){1'b0}}, gpt_q} :
    (s_axi_araddr == OFS_WUT)  ? {{(DATA_W-WUT_W){1'b0}}, wut_q} :
    (s_axi_araddr == OFS_STAT) ? stat_w :
    (s_axi_araddr == OFS_IRQ)  ? {{(DATA_W-IRQ_W){1'b0}}, irq_q} : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      arready_q <= 1'b0;
      bvalid_q  <= 1'b0;
      rvalid_q  <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      bresp_q   <= RESP_OKAY;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= '0;
    end else begin
      awready_q <= ~aw_have_d;
      wready_q  <= ~w_have_d;
      arready_q <= ~rvalid_d;
      bvalid_q  <= bvalid_d;
      rvalid_q  <= rvalid_d;
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      if (aw_hs) aw_addr_q <= s_axi_awaddr;
      if (w_hs) w_data_q <= s_axi_wdata;
      if (w_hs) w_strb_q <= s_axi_wstrb;
      if (do_write) bresp_q <= addr_hit(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      if (ar_hs) rresp_q <= addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      if (ar_hs) rdata_q <= rd_w;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q    <= CTRL_RST;
      mrt_q     <= MRT_RST;
      nrt_q     <= CNT_RST;
      gpt_q     <= CNT_RST;
      wut_q     <= WUT_RST;
      irq_q     <= IRQ_RST;
      fc_cnt_q  <= FC_RST;
      force_q   <= 1'b0;
      rx_on_q   <= 1'b0;
      squelch_q <= 1'b0;
      rc_osc_q  <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      mrt_q     <= mrt_d;
      nrt_q     <= nrt_d;
      gpt_q     <= gpt_d;
      wut_q     <= wut_d;
      irq_q     <= irq_d;
      fc_cnt_q  <= fc_cnt_d;
      force_q   <= force_d;
      rx_on_q   <= rx_on_d;
      squelch_q <= sq_d;
      rc_osc_q  <= run_d[T_WUT];
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign rx_on         = rx_on_q;
  assign squelch_on    = squelch_q;
  assign rc_osc_on     = rc_osc_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_rx_mask_hold: assert property (run_q[T_MRT] |-> !rx_on)
    else $error("rx_on high while mask timer runs");
  a_tx_eof_start: assert property (tx_eof_done && !active && mrt_q != MRT_RST &&
    nrt_q != CNT_RST && !cmd_v[C_CLR] |=> run_q[T_MRT] && run_q[T_NRT] ##1 !rx_on)
    else $error("transmit end did not start both timers");
  a_squelch_follow: assert property (run_q[T_MRT] && $past(ctrl_q[CB_SQ_EN]) |-> squelch_on)
    else $error("squelch off while mask timer runs");
  a_peer_mask_start: assert property (active && peer_field_on && mrt_q != MRT_RST &&
    !cmd_v[C_CLR] |=> run_q[T_MRT])
    else $error("peer field did not start mask timer");
  a_clear_stops: assert property (cmd_v[C_CLR] && !tstart[T_MRT] && !tstart[T_GPT]
    |=> !run_q[T_MRT] && !run_q[T_GPT])
    else $error("clear left a timer running");
  a_clear_keeps_wut: assert property (cmd_v[C_CLR] && run_q[T_WUT] && !exp_d[T_WUT]
    |=> run_q[T_WUT])
    else $error("clear stopped the wake timer");
  a_nre_flag_set: assert property (exp_q[T_NRT] |=> irq_q[IB_NRE])
    else $error("no-response expiry without flag");
  a_nrt_reply_stop: assert property (!mode1 && reply_start && run_q[T_NRT] &&
    !tstart[T_NRT] |=> !run_q[T_NRT] && !exp_q[T_NRT] ##1 !exp_q[T_NRT])
    else $error("reply did not stop no-response timer silently");
  a_nrt_mode1_clear: assert property (mode1 && cmd_v[C_CLR] && run_q[T_NRT] &&
    !exp_d[T_NRT] |=> run_q[T_NRT])
    else $error("clear stopped timer in mode 1");
  a_nrt_cmd_restart: assert property (cmd_v[C_NRT] && !active && nrt_q != CNT_RST
    |=> run_q[T_NRT] && cnt_q[T_NRT] == $past(nrt_q))
    else $error("no-response command did not reload");
  a_nrt_cmd_active: assert property (cmd_v[C_NRT] && active && !tx_eof_done &&
    !run_q[T_NRT] |=> !run_q[T_NRT])
    else $error("no-response command taken in active mode");
  a_gpt_irq_set: assert property (exp_q[T_GPT] |=> irq_q[IB_GPT])
    else $error("general timer expiry without flag");
  a_wut_cmd_start: assert property (cmd_v[C_WUT] && !wake |=> run_q[T_WUT] ##1 rc_osc_on)
    else $error("wake command did not start timer");
  a_wut_flag_set: assert property (exp_q[T_WUT] |=> irq_q[IB_WT])
    else $error("wake expiry without flag");
  a_no_osc_hold: assert property (!osc_ok && !tstart[T_NRT] && !tstop[T_NRT]
    |=> cnt_q[T_NRT] == $past(cnt_q[T_NRT]))
    else $error("no-response timer counted without crystal");
  a_expire_once: assert property (exp_q[T_GPT] |-> !run_q[T_GPT] || $past(tstart[T_GPT]))
    else $error("general timer kept running after expiry");

  c_nrt_timeout: cover property (tx_eof_done ##[1:1000] exp_q[T_NRT]);
  c_nrt_reply: cover property (run_q[T_NRT] && rx_sof && !mode1);
  c_gpt_expire: cover property (exp_q[T_GPT]);
  c_wut_expire: cover property (exp_q[T_WUT]);

endmodule
`default_nettype wire

// ==== tb/fe_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module fe_model #(
  parameter int FC_DIV = 2,
  parameter int RC_DIV = 4
) (
  input  wire logic       aclk,
  output logic            fc_tick,
  output logic            rc_tick,
  output logic            osc_ok,
  output logic            rx_busy,
  output logic [4:0]      ev
);
  int fc_c = 0;
  int rc_c = 0;
  initial begin
    fc_tick = 1'b0;
    rc_tick = 1'b0;
    osc_ok = 1'b1;
    rx_busy = 1'b0;
    ev = 5'h00;
  end
  // Carrier keeps ticking while osc_ok is low, so the gate inside the timers is what stops them
  always @(posedge aclk) begin
    fc_c <= (fc_c + 1) % FC_DIV;
    fc_tick <= (fc_c == 0);
    rc_c <= (rc_c + 1) % RC_DIV;
    rc_tick <= (rc_c == 0);
  end
  // Level inputs are changed only here, so each has a single driver
  task automatic set_osc(input logic v);
    osc_ok <= v;
  endtask
  task automatic set_busy(input logic v);
    rx_busy <= v;
  endtask
  // Events: 0 tx end, 1 reply start, 2 reply end, 3 peer field on, 4 peer field off
  task automatic fire(input int k);
    @(posedge aclk);
    ev[k] <= 1'b1;
    @(posedge aclk);
    ev[k] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import nfc_timer_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata;
  logic [STRB_W-1:0] s_axi_wstrb;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [DATA_W-1:0] s_axi_rdata;
  wire logic fc_tick, rc_tick, osc_ok, rx_busy, rx_on, squelch_on, rc_osc_on;
  wire logic [4:0] ev;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] rst_v [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h2, 32'h0, 32'h10, 32'h0};
  logic [31:0] gt_ctrl [3] = '{32'h4, 32'h8, 32'h20};
  int gt_ev [3] = '{1, 2, 4};
  fe_model fe (.aclk, .fc_tick, .rc_tick, .osc_ok, .rx_busy, .ev);
  nfc_timer_unit uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fc_tick, .osc_ok, .rc_tick,
    .tx_eof_done(ev[0]), .rx_sof(ev[1]), .rx_eof(ev[2]), .rx_busy,
    .peer_field_on(ev[3]), .peer_field_off(ev[4]), .rx_on, .squelch_on, .rc_osc_on);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic report_and_stop();
    $display("mismatches %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Whole run needs under 10000 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic chk_pin(input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk_word({30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1,
                    input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!(s_axi_arvalid && s_axi_arready));
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk_word(e, s_axi_rdata & m);
    chk_word({30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  task automatic cmd(input int k);
    wr(OFS_CMD, 32'h1 << k);
  endtask
  initial begin
    aresetn = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rst_v[i]) rd(8'(i * 4), rst_v[i]);
    rd(8'h20, 32'h0, '1, RESP_SLVERR);
    wr(8'h20, 32'h1, RESP_SLVERR);
    // Only the low byte lane is enabled, so the upper byte must stay zero
    s_axi_wstrb <= 4'h1;
    wr(OFS_NRT, 32'h1234);
    s_axi_wstrb <= 4'hf;
    rd(OFS_NRT, 32'h34);
    wr(OFS_NRT, 32'h0);
    // Mask window after transmit with squelch enabled
    wr(OFS_CTRL, 32'h1 << CB_SQ_EN);
    wr(OFS_MRT, 32'h2);
    fe.fire(0);
    wait_cyc(3);
    chk_pin(1'b0, rx_on);
    chk_pin(1'b1, squelch_on);
    wait_cyc(300);
    chk_pin(1'b1, rx_on);
    chk_pin(1'b0, squelch_on);
    rd(OFS_IRQ, 32'h0);
    // Mode 0 timeout, then a reply that stops it silently
    wr(OFS_CTRL, 32'h0);
    wr(OFS_MRT, 32'h0);
    wr(OFS_NRT, 32'h3);
    fe.fire(0);
    wait_cyc(200);
    rd(OFS_STAT, 32'h2, 32'h2);
    wait_cyc(300);
    rd(OFS_IRQ, 32'h1 << IB_NRE);
    chk_pin(1'b0, rx_on);
    wr(OFS_IRQ, 32'h7);
    fe.fire(0);
    wait_cyc(50);
    fe.fire(1);
    wait_cyc(500);
    rd(OFS_IRQ, 32'h0);
    chk_pin(1'b1, rx_on);
    // Mode 1 with a reply in progress
    wr(OFS_CTRL, 32'h1 << CB_NRT_MODE);
    fe.set_busy(1'b1);
    fe.fire(0);
    cmd(C_CLR);
    rd(OFS_STAT, 32'h2, 32'h2);
    wait_cyc(500);
    rd(OFS_IRQ, 32'h1);
    chk_pin(1'b1, rx_on);
    fe.set_busy(1'b0);
    wr(OFS_IRQ, 32'h7);
    // Long step keeps a two-count timer alive; clear stops it
    wr(OFS_CTRL, 32'h1 << CB_NRT_STEP);
    wr(OFS_NRT, 32'h2);
    cmd(C_NRT);
    wait_cyc(600);
    rd(OFS_STAT, 32'h2, 32'h2);
    cmd(C_CLR);
    rd(OFS_STAT, 32'h0, 32'h2);
    // Clear spares only the wake timer
    wr(OFS_CTRL, 32'h0);
    wr(OFS_NRT, 32'h64);
    wr(OFS_GPT, 32'h64);
    wr(OFS_WUT, 32'h0);
    wr(OFS_CMD, 32'h1c);
    rd(OFS_STAT, 32'he, 32'hf);
    chk_pin(1'b1, rc_osc_on);
    cmd(C_CLR);
    rd(OFS_STAT, 32'h8, 32'hf);
    wait_cyc(1400);
    rd(OFS_IRQ, 32'h1 << IB_WT);
    chk_pin(1'b0, rc_osc_on);
    wr(OFS_IRQ, 32'h7);
    // Every general timer trigger
    wr(OFS_GPT, 32'h8);
    for (int k = 0; k < 3; k++) begin
      wr(OFS_CTRL, gt_ctrl[k]);
      fe.fire(gt_ev[k]);
      wait_cyc(200);
      rd(OFS_IRQ, 32'h1 << IB_GPT);
      wr(OFS_IRQ, 32'h7);
    end
    wr(OFS_CTRL, 32'h0);
    cmd(C_GPT);
    wait_cyc(100);
    cmd(C_GPT);
    wait_cyc(60);
    rd(OFS_IRQ, 32'h0);
    wait_cyc(150);
    rd(OFS_IRQ, 32'h1 << IB_GPT);
    wr(OFS_IRQ, 32'h7);
    // Active mode
    wr(OFS_CTRL, 32'h1 << CB_ACTIVE);
    wr(OFS_NRT, 32'h3);
    cmd(C_NRT);
    rd(OFS_STAT, 32'h0, 32'h2);
    fe.fire(0);
    wait_cyc(500);
    rd(OFS_IRQ, 32'h1);
    wr(OFS_MRT, 32'h2);
    fe.fire(3);
    rd(OFS_STAT, 32'h1, 32'h1);
    wr(OFS_IRQ, 32'h7);
    wait_cyc(300);
    // Low-power target makes the mask step eight times longer, 512 periods instead of 64
    wr(OFS_CTRL, 32'h1 << CB_LP_TGT);
    cmd(C_MRT);
    wait_cyc(600);
    chk_pin(1'b0, rx_on);
    wait_cyc(1500);
    chk_pin(1'b1, rx_on);
    // Crystal stopped freezes the carrier timers
    wr(OFS_CTRL, 32'h0);
    wr(OFS_NRT, 32'h1);
    fe.set_osc(1'b0);
    cmd(C_NRT);
    wait_cyc(300);
    rd(OFS_STAT, 32'h2, 32'h2);
    fe.set_osc(1'b1);
    wait_cyc(200);
    rd(OFS_IRQ, 32'h1);
    report_and_stop();
  end
endmodule
`default_nettype wire
